/* iwdt_pkg.sv */
// constants of the independent watchdog timer: register map, command
// codes, field layouts and values after reset.
// assumes nothing beyond a SystemVerilog compiler.
package iwdt_pkg;

  // register byte offsets
  localparam logic [3:0] IWDT_CMD_OFS = 4'h0;
  localparam logic [3:0] IWDT_PSC_OFS = 4'h4;
  localparam logic [3:0] IWDT_RLD_OFS = 4'h8;
  localparam logic [3:0] IWDT_STAT_OFS = 4'hc;

  // command codes
  localparam logic [15:0] IWDT_CODE_UNLOCK = 16'h5555;
  localparam logic [15:0] IWDT_CODE_START = 16'hcccc;
  localparam logic [15:0] IWDT_CODE_RELOAD = 16'haaaa;

  // field widths and positions
  localparam int IWDT_CMD_W = 16;
  localparam int IWDT_PSC_W = 3;
  localparam int IWDT_CNT_W = 12;
  localparam int IWDT_PRE_W = 8;
  localparam int IWDT_STAT_PSC_PEND_BIT = 0;
  localparam int IWDT_STAT_RLD_PEND_BIT = 1;
  localparam int IWDT_STAT_RUN_BIT = 2;
  localparam int IWDT_STAT_RST_BIT = 3;

  // values after reset, and the counter value at zero
  localparam logic [2:0] IWDT_PSC_RST = 3'h0;
  localparam logic [11:0] IWDT_RLD_RST = 12'hfff;
  localparam logic [11:0] IWDT_CNT_ZERO = 12'h000;

  // oscillator ticks needed to move a write into the slow domain
  localparam logic [1:0] IWDT_UPD_TICKS = 2'h3;
  // cycles after reset release before the option strap is sampled
  localparam logic [1:0] IWDT_BOOT_CYCLES = 2'h2;

  // status of one register transfer into the slow domain
  typedef enum logic [0:0] {
    IWDT_UPD_IDLE = 1'b0,
    IWDT_UPD_BUSY = 1'b1
  } iwdt_upd_t;

endpackage

/* iwdt_top.sv */
// independent watchdog: apb register slave, prescaler, 12-bit down counter
// and system reset request, all on clk.
// assumes low_speed_osc and hw_watchdog_option come from outside the clk
// domain; core_halted and debug_freeze_bit come from logic on clk.
//
// Overview of operation
// - eight-setting prescaler drives a 12-bit down counter.
// - start code on the command register enables the watchdog and counting.
// - counter at zero while enabled raises the system reset request.
// - reload code loads the counter from the last transferred reload value at any time.
// - set hardware option bit starts the watchdog at power-on.
// - prescaler and reload writes ignored unless unlock code was last command.
// - any other command value restores write protection.
// - update status bit stays set while a register update is in progress.
// - debug freeze bit set stops counting while the core is halted.
// - counter advances on the low-speed oscillator, not on bus activity.
// - prescale codes 0 to 6 divide by 4 to 256; code 7 by 256.
// - reload pending bit reads set during transfer; software waits for clear.
// - reload value resets to all ones for the longest timeout.
`timescale 1ns/1ps

module iwdt_top
  import iwdt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_osc,
  input wire logic hw_watchdog_option,
  input wire logic core_halted,
  input wire logic debug_freeze_bit,
  output logic system_reset_req
);

  // the decode reads address bits above the four offset bits
  if (ADDR_W < 5) begin : g_addr_w_check
    $error("iwdt_top: ADDR_W must be at least 5");
  end

  // last prescaler count for a division code
  function automatic logic [IWDT_PRE_W-1:0] div_last(
      input logic [IWDT_PSC_W-1:0] sel);
    logic [IWDT_PRE_W-1:0] v;
    v = 8'h00;
    case (sel)
      3'h0: v = 8'h03;
      3'h1: v = 8'h07;
      3'h2: v = 8'h0f;
      3'h3: v = 8'h1f;
      3'h4: v = 8'h3f;
      3'h5: v = 8'h7f;
      default: v = 8'hff;
    endcase
    return v;
  endfunction

  // ---------------- input synchronisers ----------------
  logic osc_meta_reg, osc_sync_reg, osc_prev_reg;
  logic opt_meta_reg, opt_sync_reg;
  logic osc_meta_next, osc_sync_next, osc_prev_next;
  logic opt_meta_next, opt_sync_next;
  logic osc_tick;

  always_comb begin
    osc_meta_next = low_speed_osc;
    osc_sync_next = osc_meta_reg;
    osc_prev_next = osc_sync_reg;
    opt_meta_next = hw_watchdog_option;
    opt_sync_next = opt_meta_reg;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      opt_meta_reg <= 1'b0;
      opt_sync_reg <= 1'b0;
    end else begin
      osc_meta_reg <= osc_meta_next;
      osc_sync_reg <= osc_sync_next;
      osc_prev_reg <= osc_prev_next;
      opt_meta_reg <= opt_meta_next;
      opt_sync_reg <= opt_sync_next;
    end
  end

  // one pulse per rising oscillator edge
  assign osc_tick = osc_sync_reg & ~osc_prev_reg;

  // ---------------- apb slave ----------------
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic unlock_reg, unlock_next;
  logic [IWDT_PSC_W-1:0] psc_stage_reg, psc_stage_next;
  logic [IWDT_CNT_W-1:0] rld_stage_reg, rld_stage_next;
  logic [3:0] ofs;
  logic mapped, setup, wr_take;
  logic cmd_wr, psc_wr, rld_wr;
  logic [IWDT_CMD_W-1:0] cmd_val;

  // watchdog state read back by the bus
  iwdt_upd_t psc_upd_reg, rld_upd_reg;
  logic running_reg;
  logic reset_req_reg;

  assign ofs = paddr[3:0];
  assign mapped = (paddr[ADDR_W-1:4] == '0) && (ofs[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign wr_take = psel && penable && pready_reg && pwrite && mapped;
  assign cmd_val = pwdata[IWDT_CMD_W-1:0];
  assign cmd_wr = wr_take && (ofs == IWDT_CMD_OFS);
  assign psc_wr = wr_take && (ofs == IWDT_PSC_OFS) && unlock_reg;
  assign rld_wr = wr_take && (ofs == IWDT_RLD_OFS) && unlock_reg;

  always_comb begin
    prdata_next = prdata_reg;
    pready_next = setup;
    pslverr_next = 1'b0;
    unlock_next = unlock_reg;
    psc_stage_next = psc_stage_reg;
    rld_stage_next = rld_stage_reg;
    if (setup) begin
      pslverr_next = !mapped;
      prdata_next = 32'h00000000;
      if (!pwrite && mapped) begin
        case (ofs)
          IWDT_PSC_OFS: prdata_next[IWDT_PSC_W-1:0] = psc_stage_reg;
          IWDT_RLD_OFS: prdata_next[IWDT_CNT_W-1:0] = rld_stage_reg;
          IWDT_STAT_OFS: begin
            prdata_next[IWDT_STAT_PSC_PEND_BIT] =
                (psc_upd_reg == IWDT_UPD_BUSY);
            prdata_next[IWDT_STAT_RLD_PEND_BIT] =
                (rld_upd_reg == IWDT_UPD_BUSY);
            prdata_next[IWDT_STAT_RUN_BIT] = running_reg;
            prdata_next[IWDT_STAT_RST_BIT] = reset_req_reg;
          end
          default: prdata_next = 32'h00000000;
        endcase
      end
    end
    if (cmd_wr) begin
      unlock_next = (cmd_val == IWDT_CODE_UNLOCK);
    end
    if (psc_wr) begin
      psc_stage_next = pwdata[IWDT_PSC_W-1:0];
    end
    if (rld_wr) begin
      rld_stage_next = pwdata[IWDT_CNT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      unlock_reg <= 1'b0;
      psc_stage_reg <= IWDT_PSC_RST;
      rld_stage_reg <= IWDT_RLD_RST;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      unlock_reg <= unlock_next;
      psc_stage_reg <= psc_stage_next;
      rld_stage_reg <= rld_stage_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ---------------- watchdog core ----------------
  iwdt_upd_t psc_upd_next, rld_upd_next;
  logic [1:0] psc_wait_reg, psc_wait_next;
  logic [1:0] rld_wait_reg, rld_wait_next;
  logic [IWDT_PSC_W-1:0] psc_act_reg, psc_act_next;
  logic [IWDT_CNT_W-1:0] rld_act_reg, rld_act_next;
  logic [IWDT_PRE_W-1:0] pre_reg, pre_next;
  logic [IWDT_CNT_W-1:0] cnt_reg, cnt_next;
  logic running_next;
  logic reset_req_next;
  logic [1:0] boot_reg, boot_next;
  logic frozen, step, pre_wrap;

  // counting pauses only when both the freeze bit and the halt are present
  assign frozen = debug_freeze_bit && core_halted;
  assign step = osc_tick && running_reg && !frozen;
  assign pre_wrap = step && (pre_reg == div_last(psc_act_reg));

  always_comb begin
    psc_upd_next = psc_upd_reg;
    rld_upd_next = rld_upd_reg;
    psc_wait_next = psc_wait_reg;
    rld_wait_next = rld_wait_reg;
    psc_act_next = psc_act_reg;
    rld_act_next = rld_act_reg;
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    running_next = running_reg;
    reset_req_next = reset_req_reg;
    boot_next = boot_reg;

    // transfer of staged values into the slow side
    if (psc_upd_reg == IWDT_UPD_BUSY && osc_tick) begin
      if (psc_wait_reg == IWDT_UPD_TICKS - 2'h1) begin
        psc_act_next = psc_stage_reg;
        psc_upd_next = IWDT_UPD_IDLE;
      end else begin
        psc_wait_next = psc_wait_reg + 2'h1;
      end
    end
    if (rld_upd_reg == IWDT_UPD_BUSY && osc_tick) begin
      if (rld_wait_reg == IWDT_UPD_TICKS - 2'h1) begin
        rld_act_next = rld_stage_reg;
        rld_upd_next = IWDT_UPD_IDLE;
      end else begin
        rld_wait_next = rld_wait_reg + 2'h1;
      end
    end
    // a new write restarts the transfer; a finishing one still loads the older staged value
    if (psc_wr) begin
      psc_upd_next = IWDT_UPD_BUSY;
      psc_wait_next = 2'h0;
    end
    if (rld_wr) begin
      rld_upd_next = IWDT_UPD_BUSY;
      rld_wait_next = 2'h0;
    end

    // prescaler and down counter
    if (step) begin
      pre_next = pre_wrap ? 8'h00 : pre_reg + 8'h01;
    end
    if (pre_wrap && cnt_reg != IWDT_CNT_ZERO) begin
      cnt_next = cnt_reg - 12'h001;
    end
    if (running_reg && cnt_reg == IWDT_CNT_ZERO) begin
      reset_req_next = 1'b1;
    end

    // strap sampled once the synchroniser has settled
    if (boot_reg != IWDT_BOOT_CYCLES) begin
      boot_next = boot_reg + 2'h1;
    end else if (boot_reg == IWDT_BOOT_CYCLES && opt_sync_reg) begin
      running_next = 1'b1;
    end

    if (cmd_wr && cmd_val == IWDT_CODE_START) begin
      running_next = 1'b1;
    end
    if (cmd_wr && cmd_val == IWDT_CODE_RELOAD) begin
      cnt_next = rld_act_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psc_upd_reg <= IWDT_UPD_IDLE;
      rld_upd_reg <= IWDT_UPD_IDLE;
      psc_wait_reg <= 2'h0;
      rld_wait_reg <= 2'h0;
      psc_act_reg <= IWDT_PSC_RST;
      rld_act_reg <= IWDT_RLD_RST;
      pre_reg <= 8'h00;
      cnt_reg <= IWDT_RLD_RST;
      running_reg <= 1'b0;
      reset_req_reg <= 1'b0;
      boot_reg <= 2'h0;
    end else begin
      psc_upd_reg <= psc_upd_next;
      rld_upd_reg <= rld_upd_next;
      psc_wait_reg <= psc_wait_next;
      rld_wait_reg <= rld_wait_next;
      psc_act_reg <= psc_act_next;
      rld_act_reg <= rld_act_next;
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      running_reg <= running_next;
      reset_req_reg <= reset_req_next;
      boot_reg <= boot_next;
    end
  end

  assign system_reset_req = reset_req_reg;

endmodule // iwdt_top

/* iwdt_chk.sv */
// checker for the watchdog: apb timing, read layout, reset request.
// assumes it is bound to iwdt_top and sees its ports only.
`timescale 1ns/1ps
module iwdt_chk
  import iwdt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_speed_osc,
  input wire logic hw_watchdog_option,
  input wire logic core_halted,
  input wire logic debug_freeze_bit,
  input wire logic system_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rd_ok;
  logic frz;
  assign rd_ok = pready && psel && !pwrite && !pslverr;
  assign frz = debug_freeze_bit && core_halted && !system_reset_req;
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error data");
  property p_cmd_rd;
    rd_ok && paddr == ADDR_W'(IWDT_CMD_OFS) |-> prdata == 32'h0;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command readable");
  property p_psc_rd;
    rd_ok && paddr == ADDR_W'(IWDT_PSC_OFS) |-> prdata[31:3] == 29'h0;
  endproperty
  a_psc_rd: assert property (p_psc_rd) else $error("prescale bits");
  property p_rld_rd;
    rd_ok && paddr == ADDR_W'(IWDT_RLD_OFS) |-> prdata[31:12] == 20'h0;
  endproperty
  a_rld_rd: assert property (p_rld_rd) else $error("reload bits");
  property p_stat_rd;
    rd_ok && paddr == ADDR_W'(IWDT_STAT_OFS) |-> prdata[31:4] == 28'h0;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status bits");
  property p_req_hold;
    system_reset_req |=> system_reset_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_freeze;
    frz [*4] |=> !system_reset_req;
  endproperty
  a_freeze: assert property (p_freeze) else $error("count while frozen");
  c_req: cover property ($rose(system_reset_req));
  c_err: cover property (pslverr);
  c_frz: cover property (frz [*4]);
endmodule // iwdt_chk

bind iwdt_top iwdt_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .low_speed_osc(low_speed_osc),
  .hw_watchdog_option(hw_watchdog_option), .core_halted(core_halted),
  .debug_freeze_bit(debug_freeze_bit), .system_reset_req(system_reset_req)
);

/* independent_watchdog_timer_bench.sv */
// self-checking bench for the watchdog: apb tasks and scenarios.
// assumes iwdt_top, its package and its checker are compiled first.
`timescale 1ns/1ps
module independent_watchdog_timer_bench;
  import iwdt_pkg::*;
  localparam logic [11:0] A_CMD = {8'h0, IWDT_CMD_OFS};
  localparam logic [11:0] A_PSC = {8'h0, IWDT_PSC_OFS};
  localparam logic [11:0] A_RLD = {8'h0, IWDT_RLD_OFS};
  localparam logic [11:0] A_STAT = {8'h0, IWDT_STAT_OFS};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, req, perr;
  logic hw_opt = 1'b0;
  logic halt = 1'b0;
  logic frz = 1'b0;
  logic [2:0] osc = 3'h0;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  // slow oscillator: one rising edge every 8 clocks
  always @(posedge clk) osc <= osc + 3'h1;
  iwdt_top dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_speed_osc(osc[2]),
    .hw_watchdog_option(hw_opt), .core_halted(halt),
    .debug_freeze_bit(frz), .system_reset_req(req)
  );
  task automatic summarize();
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(rdat, exp);
  endtask
  task automatic wt(input int n);
    repeat (n * 8) @(posedge clk);
  endtask
  task automatic do_reset(input logic strap);
    rst_n <= 1'b0;
    hw_opt <= strap;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    do_reset(1'b0);
    check({31'h0, req}, 32'h0);
    rd(A_RLD, 32'h0000_0fff);
    rd(A_PSC, 32'h0);
    rd(A_STAT, 32'h0);
    wr(A_RLD, 32'h1);
    rd(A_RLD, 32'h0000_0fff);
    rd(12'h010, 32'h0);
    check({31'h0, perr}, 32'h1);
    wr(A_CMD, {16'h0, IWDT_CODE_UNLOCK});
    wr(A_PSC, 32'h7);
    wr(A_RLD, 32'h5);
    rd(A_STAT, 32'h3);
    rd(A_PSC, 32'h7);
    wr(A_PSC, 32'h0);
    wt(5);
    rd(A_STAT, 32'h0);
    wr(A_CMD, 32'h1234);
    wr(A_RLD, 32'h7);
    rd(A_RLD, 32'h5);
    rd(A_CMD, 32'h0);
    frz <= 1'b1;
    halt <= 1'b1;
    wr(A_CMD, {16'h0, IWDT_CODE_RELOAD});
    wr(A_CMD, {16'h0, IWDT_CODE_START});
    rd(A_STAT, 32'h4);
    wt(40);
    check({31'h0, req}, 32'h0);
    frz <= 1'b0;
    repeat (6) begin
      wt(10);
      wr(A_CMD, {16'h0, IWDT_CODE_RELOAD});
    end
    check({31'h0, req}, 32'h0);
    wt(12);
    check({31'h0, req}, 32'h0);
    wt(14);
    check({31'h0, req}, 32'h1);
    rd(A_STAT, 32'hc);
    halt <= 1'b0;
    do_reset(1'b1);
    check({31'h0, req}, 32'h0);
    rd(A_STAT, 32'h4);
    wr(A_CMD, {16'h0, IWDT_CODE_UNLOCK});
    wr(A_PSC, 32'h1);
    wr(A_RLD, 32'h2);
    wt(3);
    wr(A_CMD, {16'h0, IWDT_CODE_RELOAD});
    wt(10);
    check({31'h0, req}, 32'h0);
    wt(6);
    check({31'h0, req}, 32'h1);
    summarize();
  end
endmodule // independent_watchdog_timer_bench
